// file: core/acr_pkg.sv
// Purpose: Shared constants for the antenna check, random generator and secure supply register bank.
// Assumes: 16-bit register addresses, 8-bit data.
// Notes: Offsets are byte addresses on the plain register port.
package acr_pkg;
  localparam int ADDR_W = 16;
  localparam logic [15:0] OFF_RANDOM_NUMBER_DATA = 16'h6105;
  localparam logic [15:0] OFF_ANTENNA_CURRENT_CHECK = 16'h610C;
  localparam logic [15:0] OFF_RANDOM_AND_SECURE_SUPPLY_CTRL = 16'h610D;
  localparam logic [15:0] OFF_IRQ_STATUS = 16'h6110;
  localparam logic [15:0] OFF_IRQ_MASK = 16'h6111;
  localparam logic [7:0] RST_ANTENNA_CURRENT_CHECK = 8'h00;
  localparam logic [7:0] RST_RANDOM_AND_SECURE_SUPPLY_CTRL = 8'h41;
  localparam logic [7:0] RST_RANDOM_NUMBER_DATA = 8'h00;
  localparam logic [7:0] RNG_SEED = 8'hA5;
  localparam int ACC_EN_BIT = 0;
  localparam int ACC_ITHH_LSB = 1;
  localparam int ACC_ITHL_LSB = 4;
  localparam int ACC_UP_BIT = 6;
  localparam int ACC_BOT_BIT = 7;
  localparam int RSC_READY_BIT = 1;
  localparam int RSC_FORCE_BIT = 2;
  localparam int RSC_SW_EN_BIT = 4;
  localparam int RSC_OVL_BIT = 5;
  localparam int RSC_MASK_BIT = 6;
  localparam int IRQ_READY = 0;
  localparam int IRQ_UP = 1;
  localparam int IRQ_BOT = 2;
  localparam int IRQ_OVL = 3;
  localparam logic [7:0] IRQ_USED = 8'h0F;
  localparam int RSC_FIXED_ONE_BIT = 0;
  localparam int RNG_PERIOD_CYCLES = 8;
endpackage

// file: core/acr_bank.sv
// Purpose: Control and status registers for antenna current check, random generator and secure supply switch.
// Assumes: Synchronous inputs on clk_sys; firmware-only plain register port.
// Notes: Analogue comparators and switch sit outside; this block steers and reports them.
// Functional notes
// - Monitoring runs only while enable bit set.
// - Limit crossings reported via bits 7, 6.
// - High flag bit 6 above high threshold.
// - Low flag bit 7 below low threshold.
// - Low threshold codes 10/11 give 25/35 mA.
// - High threshold codes select 45 to 150 mA.
// - No result pin; read flags only.
// - Random byte sits in data bits 7:0.
// - Valid bit 1 set on fresh number.
// - Reading data register clears valid bit.
// - Force run bit overrides contactless unit control.
// - Switch enable bit powers secure supply.
// - Overcurrent bit mirrors current limitation state.
// - Pad mask forces inputs to 0/1.
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/10ps
module acr_bank #(
  parameter int RNG_PERIOD = acr_pkg::RNG_PERIOD_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [acr_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic irq,
  output logic monitor_enable,
  output logic [1:0] low_threshold_sel,
  output logic [2:0] high_threshold_sel,
  input wire logic current_above_high,
  input wire logic current_below_low,
  input wire logic contactless_unit_rng_run,
  output logic rng_running,
  output logic secure_switch_enable,
  input wire logic secure_switch_overload,
  input wire logic secure_signal_in_pad,
  input wire logic auxiliary_port_pin_pad,
  output logic secure_signal_in,
  output logic auxiliary_port_pin
);
  import acr_pkg::*;

  // ------------------------------------------------------------
  // Register state
  // ------------------------------------------------------------
  // Software-visible register copies.
  logic [7:0] check_ctrl;
  logic [7:0] rng_ctrl;
  logic [7:0] rng_data;
  logic [7:0] irq_status;
  logic [7:0] irq_mask;

  // Antenna check flags and the delayed copies used for edge detection.
  logic flag_up;
  logic flag_bot;
  logic flag_up_d;
  logic flag_bot_d;
  logic ovl_d;

  // Generator state.
  logic [7:0] lfsr;
  logic [7:0] rng_count;
  logic rng_fresh;
  logic next_ready;

  // Qualified strobes, decoded once.
  logic wr_check_sel;
  logic wr_supply_sel;
  logic wr_data_sel;
  logic wr_status_sel;
  logic wr_mask_sel;
  logic rd_data_hit;

  // Derived control and readback words.
  logic pad_mask_on;
  logic [7:0] check_readback;
  logic [7:0] supply_readback;
  logic [7:0] next_rdata;

  // Interrupt events.
  logic up_rise;
  logic bot_rise;
  logic ovl_rise;
  logic [7:0] next_irq_set;

  // ------------------------------------------------------------
  // Address decode
  // ------------------------------------------------------------
  // Exact compare on the full address, so that no alias ever reaches a register.
  function automatic logic hit(input logic [15:0] a, input logic [15:0] off);
    return a == off;
  endfunction

  // Strobes are qualified here once; every register write below uses these selects, while the read mux decodes reg_addr itself.
  assign wr_check_sel = reg_wr && hit(reg_addr, OFF_ANTENNA_CURRENT_CHECK);
  assign wr_supply_sel = reg_wr && hit(reg_addr, OFF_RANDOM_AND_SECURE_SUPPLY_CTRL);
  assign wr_data_sel = reg_wr && hit(reg_addr, OFF_RANDOM_NUMBER_DATA);
  assign wr_status_sel = reg_wr && hit(reg_addr, OFF_IRQ_STATUS);
  assign wr_mask_sel = reg_wr && hit(reg_addr, OFF_IRQ_MASK);
  assign rd_data_hit = reg_rd && hit(reg_addr, OFF_RANDOM_NUMBER_DATA);

  // ------------------------------------------------------------
  // Antenna check control register
  // ------------------------------------------------------------
  // The flag bits are read-only, so a write keeps only the six control bits.

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      check_ctrl <= RST_ANTENNA_CURRENT_CHECK;
    end else if (wr_check_sel) begin
      check_ctrl <= {2'b00, reg_wdata[5:0]};
    end
  end

  // ------------------------------------------------------------
  // Antenna current check
  // ------------------------------------------------------------
  // Threshold codes pass straight to the analogue comparators; code 10 is 25 mA and 11 is 35 mA,
  // while 000..111 on the high side step 45, 60, 75, 90, 105, 120, 130, 150 mA.
  assign monitor_enable = check_ctrl[ACC_EN_BIT];
  assign low_threshold_sel = check_ctrl[ACC_ITHL_LSB +: 2];
  assign high_threshold_sel = check_ctrl[ACC_ITHH_LSB +: 3];

  // Flags are re-sampled every cycle so that a cleared fault reads clean again.
  // The result is only meaningful while the transmitter drives the antenna; the block cannot tell.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      flag_up <= 1'b0;
    end else if (!check_ctrl[ACC_EN_BIT]) begin
      flag_up <= 1'b0;
    end else begin
      flag_up <= current_above_high;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      flag_bot <= 1'b0;
    end else if (!check_ctrl[ACC_EN_BIT]) begin
      flag_bot <= 1'b0;
    end else begin
      flag_bot <= current_below_low;
    end
  end

  // ------------------------------------------------------------
  // Random generator
  // ------------------------------------------------------------
  assign rng_running = rng_ctrl[RSC_FORCE_BIT] || contactless_unit_rng_run;

  function automatic logic period_end(input logic [7:0] count);
    return count == 8'(RNG_PERIOD - 1);
  endfunction

  // Taps and seed only need to look random to firmware; this is no cryptographic source.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      lfsr <= RNG_SEED;
    end else if (rng_running) begin
      lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
    end
  end

  // The count only advances while running, so a paused generator resumes mid-period.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rng_count <= 8'h00;
    end else if (rng_running) begin
      if (period_end(rng_count)) begin
        rng_count <= 8'h00;
      end else begin
        rng_count <= rng_count + 8'h01;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rng_fresh <= 1'b0;
    end else begin
      rng_fresh <= rng_running && period_end(rng_count);
    end
  end

  // A software write to the data register is kept until the next fresh number lands.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rng_data <= RST_RANDOM_NUMBER_DATA;
    end else if (rng_fresh) begin
      rng_data <= lfsr;
    end else if (wr_data_sel) begin
      rng_data <= reg_wdata;
    end
  end

  // ------------------------------------------------------------
  // Generator and secure supply control
  // ------------------------------------------------------------
  // A fresh number beats both a write and a read in the same cycle, so no number goes unflagged.
  always_comb begin
    next_ready = rng_ctrl[RSC_READY_BIT];
    if (rng_fresh) begin
      next_ready = 1'b1;
    end else if (rd_data_hit) begin
      next_ready = 1'b0;
    end else if (wr_supply_sel) begin
      next_ready = reg_wdata[RSC_READY_BIT];
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rng_ctrl <= RST_RANDOM_AND_SECURE_SUPPLY_CTRL;
    end else begin
      if (wr_supply_sel) begin
        rng_ctrl[RSC_MASK_BIT] <= reg_wdata[RSC_MASK_BIT];
        rng_ctrl[RSC_SW_EN_BIT] <= reg_wdata[RSC_SW_EN_BIT];
        rng_ctrl[RSC_FORCE_BIT] <= reg_wdata[RSC_FORCE_BIT];
      end
      rng_ctrl[RSC_READY_BIT] <= next_ready;
    end
  end

  // The mask leaves reset set, so the internal pad copies sit idle until firmware releases them.
  assign pad_mask_on = rng_ctrl[RSC_MASK_BIT];
  // Only the enable leaves here; holding the supply at ground while off is the switch's job.
  assign secure_switch_enable = rng_ctrl[RSC_SW_EN_BIT];
  assign secure_signal_in = pad_mask_on ? 1'b0 : secure_signal_in_pad;
  assign auxiliary_port_pin = pad_mask_on ? 1'b1 : auxiliary_port_pin_pad;

  // ------------------------------------------------------------
  // Interrupts
  // ------------------------------------------------------------
  // Delayed copies leave reset at zero like the flags, so no false edge follows reset.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      flag_up_d <= 1'b0;
    end else begin
      flag_up_d <= flag_up;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      flag_bot_d <= 1'b0;
    end else begin
      flag_bot_d <= flag_bot;
    end
  end

  // The overload input is a level from the limiter; only its rising edge raises an event.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ovl_d <= 1'b0;
    end else begin
      ovl_d <= secure_switch_overload;
    end
  end

  assign up_rise = flag_up && !flag_up_d;
  assign bot_rise = flag_bot && !flag_bot_d;
  assign ovl_rise = secure_switch_overload && !ovl_d;

  always_comb begin
    next_irq_set = 8'h00;
    next_irq_set[IRQ_READY] = rng_fresh;
    next_irq_set[IRQ_UP] = up_rise;
    next_irq_set[IRQ_BOT] = bot_rise;
    next_irq_set[IRQ_OVL] = ovl_rise;
  end

  // Clear first, then set, so that an event in the clearing cycle survives.
  function automatic logic [7:0] sticky_update(input logic [7:0] cur, input logic [7:0] clr,
    input logic [7:0] set);
    return ((cur & ~clr) | set) & IRQ_USED;
  endfunction

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      irq_status <= 8'h00;
    end else if (wr_status_sel) begin
      irq_status <= sticky_update(irq_status, reg_wdata, next_irq_set);
    end else begin
      irq_status <= sticky_update(irq_status, 8'h00, next_irq_set);
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      irq_mask <= 8'h00;
    end else if (wr_mask_sel) begin
      irq_mask <= reg_wdata & IRQ_USED;
    end
  end

  // Level output; it stays high until every unmasked status bit has been cleared.
  assign irq = |(irq_status & irq_mask);

  // ------------------------------------------------------------
  // Read port
  // ------------------------------------------------------------
  // Bits 7 and 6 carry the live check result; its rising edges also set interrupt status bits 1 and 2.
  always_comb begin
    check_readback = 8'h00;
    check_readback[ACC_BOT_BIT] = flag_bot;
    check_readback[ACC_UP_BIT] = flag_up;
    check_readback[5:0] = check_ctrl[5:0];
  end

  // Reserved bits read fixed values; the overload bit is the live limiter state, not a latch.
  always_comb begin
    supply_readback = 8'h00;
    supply_readback[RSC_FIXED_ONE_BIT] = 1'b1;
    supply_readback[RSC_READY_BIT] = rng_ctrl[RSC_READY_BIT];
    supply_readback[RSC_FORCE_BIT] = rng_ctrl[RSC_FORCE_BIT];
    supply_readback[RSC_SW_EN_BIT] = rng_ctrl[RSC_SW_EN_BIT];
    supply_readback[RSC_OVL_BIT] = secure_switch_overload;
    supply_readback[RSC_MASK_BIT] = rng_ctrl[RSC_MASK_BIT];
  end

  always_comb begin
    next_rdata = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        OFF_RANDOM_NUMBER_DATA: begin
          next_rdata = rng_data;
        end
        OFF_ANTENNA_CURRENT_CHECK: begin
          next_rdata = check_readback;
        end
        OFF_RANDOM_AND_SECURE_SUPPLY_CTRL: begin
          next_rdata = supply_readback;
        end
        OFF_IRQ_STATUS: begin
          next_rdata = irq_status;
        end
        OFF_IRQ_MASK: begin
          next_rdata = irq_mask;
        end
        default: begin
          next_rdata = 8'h00;
        end
      endcase
    end
  end

  // Read data stand for one cycle and then return to zero, so a stale value is never taken twice.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= next_rdata;
    end
  end
endmodule

// file: sim/acr_bank_asserts.sv
// Purpose: Port checks for the register bank.
// Assumes: One clock domain, rstn active low.
// Notes: Bound from the bench top file.
`timescale 1ns/10ps
module acr_bank_asserts #(
  parameter int RNG_PERIOD = 8
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [acr_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic irq,
  input wire logic monitor_enable,
  input wire logic [1:0] low_threshold_sel,
  input wire logic [2:0] high_threshold_sel,
  input wire logic current_above_high,
  input wire logic current_below_low,
  input wire logic contactless_unit_rng_run,
  input wire logic rng_running,
  input wire logic secure_switch_enable,
  input wire logic secure_switch_overload,
  input wire logic secure_signal_in_pad,
  input wire logic auxiliary_port_pin_pad,
  input wire logic secure_signal_in,
  input wire logic auxiliary_port_pin
);
  import acr_pkg::*;
  // ----------
  // Properties
  // ----------
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  logic ck_rd;
  logic sc_rd;
  assign ck_rd = reg_rd && reg_addr == OFF_ANTENNA_CURRENT_CHECK;
  assign sc_rd = reg_rd && reg_addr == OFF_RANDOM_AND_SECURE_SUPPLY_CTRL;
  flag_follow_a: assert property (
    ck_rd && monitor_enable && $past(monitor_enable) && $stable(current_above_high) && $stable(current_below_low)
    |=> reg_rdata[7:6] == $past({current_below_low, current_above_high})) else $error("flags differ");
  flag_off_a: assert property (
    ck_rd && !monitor_enable && !$past(monitor_enable) |=> reg_rdata[7:6] == 2'h0) else $error("flags while off");
  ctrl_write_a: assert property (
    reg_wr && reg_addr == OFF_ANTENNA_CURRENT_CHECK
    |=> {low_threshold_sel, high_threshold_sel, monitor_enable} == $past(reg_wdata[5:0])) else $error("ctrl lost");
  switch_write_a: assert property (
    reg_wr && reg_addr == OFF_RANDOM_AND_SECURE_SUPPLY_CTRL
    |=> secure_switch_enable == $past(reg_wdata[4])) else $error("switch enable lost");
  supply_read_a: assert property (
    sc_rd |=> reg_rdata[5:4] == $past({secure_switch_overload, secure_switch_enable}) && reg_rdata[0])
    else $error("supply status wrong");
  rng_run_a: assert property (
    contactless_unit_rng_run |-> rng_running) else $error("generator not running");
  pad_mask_a: assert property (
    secure_signal_in != secure_signal_in_pad || auxiliary_port_pin != auxiliary_port_pin_pad
    |-> !secure_signal_in && auxiliary_port_pin) else $error("pad override wrong");
  idle_read_a: assert property (
    !reg_rd |=> reg_rdata == 8'h00) else $error("read data not idle");
  irq_masked_a: assert property (
    reg_wr && reg_addr == OFF_IRQ_MASK && reg_wdata[3:0] == 4'h0 |=> !irq) else $error("irq not masked");
endmodule

// file: sim/tb_acr_bank.sv
// Purpose: Self-checking bench for the register bank.
// Assumes: 25 MHz clock, reset held three cycles.
// Notes: Generator period set to 8; the generator run waits of PER + 4 cycles derive from it.
`timescale 1ns/10ps
module tb_acr_bank;
  import acr_pkg::*;
  localparam int PER = 8;
  logic clk_sys, rstn, reg_wr, reg_rd, current_above_high, current_below_low, contactless_unit_rng_run;
  logic secure_switch_overload, secure_signal_in_pad, auxiliary_port_pin_pad;
  logic irq, monitor_enable, rng_running, secure_switch_enable, secure_signal_in, auxiliary_port_pin;
  logic [15:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, v, d;
  logic [1:0] low_threshold_sel;
  logic [2:0] high_threshold_sel;
  int err_count, checked, seed;
  acr_bank #(.RNG_PERIOD(PER)) uut (.clk_sys, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .irq, .monitor_enable, .low_threshold_sel, .high_threshold_sel, .current_above_high, .current_below_low,
    .contactless_unit_rng_run, .rng_running, .secure_switch_enable, .secure_switch_overload,
    .secure_signal_in_pad, .auxiliary_port_pin_pad, .secure_signal_in, .auxiliary_port_pin);
  // ----------
  // Helpers
  // ----------
  function automatic logic [7:0] pad_exp(input logic m, input logic [1:0] p);
    return m ? 8'h01 : {6'h00, p};
  endfunction
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    checked++;
    if (s !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] dv);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= dv;
    reg_wr <= 1'h1;
    @(posedge clk_sys);
    reg_wr <= 1'h0;
    #1;
  endtask
  task automatic rd(input logic [15:0] a);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge clk_sys);
    reg_rd <= 1'h0;
    #1 v = reg_rdata;
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // ----------
  // Sequence
  // ----------
  initial begin
    clk_sys = 1'h0;
    forever #20 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (2000) @(posedge clk_sys);
    err_count++;
    stop_test;
  end
  initial begin
    seed = 32'h8C587403;
    {rstn, reg_wr, reg_rd, current_above_high, current_below_low, contactless_unit_rng_run} = 6'h00;
    {secure_switch_overload, secure_signal_in_pad, auxiliary_port_pin_pad, reg_addr, reg_wdata} = 27'h0;
    repeat (3) @(posedge clk_sys);
    rstn <= 1'h1;
    rd(OFF_RANDOM_AND_SECURE_SUPPLY_CTRL);
    chk("supply reset", v, RST_RANDOM_AND_SECURE_SUPPLY_CTRL);
    rd(16'h6100);
    chk("unmapped", v, 8'h00);
    for (int i = 0; i < 16; i++) begin
      d = {2'h3, 1'h1, i[3:0], 1'($random(seed))};
      wr(OFF_ANTENNA_CURRENT_CHECK, d);
      rd(OFF_ANTENNA_CURRENT_CHECK);
      chk("high sel", {5'h00, high_threshold_sel}, {5'h00, d[3:1]});
      chk("low sel", {6'h00, low_threshold_sel}, {6'h00, d[5:4]});
      chk("check ctrl", v, {2'h0, d[5:0]});
    end
    $display("test thresholds done");
    wr(OFF_ANTENNA_CURRENT_CHECK, 8'h35);
    for (int i = 0; i < 4; i++) begin
      {current_below_low, current_above_high} <= i[1:0];
      repeat (3) @(posedge clk_sys);
      rd(OFF_ANTENNA_CURRENT_CHECK);
      chk("flags", v, {i[1:0], 6'h35});
    end
    wr(OFF_ANTENNA_CURRENT_CHECK, 8'h34);
    repeat (2) @(posedge clk_sys);
    rd(OFF_ANTENNA_CURRENT_CHECK);
    chk("flags off", v, 8'h34);
    $display("test flags done");
    wr(OFF_IRQ_MASK, 8'h01);
    wr(OFF_RANDOM_AND_SECURE_SUPPLY_CTRL, 8'h44);
    chk("forced run", {7'h00, rng_running}, 8'h01);
    repeat (PER + 4) @(posedge clk_sys);
    wr(OFF_RANDOM_AND_SECURE_SUPPLY_CTRL, 8'h42);
    rd(OFF_RANDOM_AND_SECURE_SUPPLY_CTRL);
    chk("fresh flag", v, 8'h43);
    wr(OFF_RANDOM_NUMBER_DATA, 8'h5A);
    rd(OFF_RANDOM_NUMBER_DATA);
    chk("data", v, 8'h5A);
    repeat (20) @(posedge clk_sys);
    rd(OFF_RANDOM_AND_SECURE_SUPPLY_CTRL);
    chk("flag cleared", v, 8'h41);
    contactless_unit_rng_run <= 1'h1;
    repeat (PER + 4) @(posedge clk_sys);
    contactless_unit_rng_run <= 1'h0;
    rd(OFF_RANDOM_AND_SECURE_SUPPLY_CTRL);
    chk("unit run", v, 8'h43);
    chk("irq set", {7'h00, irq}, 8'h01);
    wr(OFF_IRQ_MASK, 8'h00);
    chk("irq masked", {7'h00, irq}, 8'h00);
    wr(OFF_IRQ_MASK, 8'h01);
    wr(OFF_IRQ_STATUS, 8'h0F);
    chk("irq cleared", {7'h00, irq}, 8'h00);
    $display("test generator done");
    for (int i = 0; i < 8; i++) begin
      d = 8'($random(seed));
      {secure_signal_in_pad, auxiliary_port_pin_pad, secure_switch_overload} <= d[2:0];
      if (i == 4) begin
        wr(OFF_RANDOM_AND_SECURE_SUPPLY_CTRL, 8'h50);
        wr(OFF_RANDOM_AND_SECURE_SUPPLY_CTRL, 8'h10);
      end
      rd(OFF_RANDOM_AND_SECURE_SUPPLY_CTRL);
      chk("pads", {6'h00, secure_signal_in, auxiliary_port_pin}, pad_exp(i < 4, d[2:1]));
      chk("supply", v & 8'hF1, {1'h0, i < 4, d[0], i >= 4, 4'h1});
      chk("switch", {7'h00, secure_switch_enable}, {7'h00, i >= 4});
    end
    $display("test supply done");
    stop_test;
  end
endmodule
bind acr_bank acr_bank_asserts #(.RNG_PERIOD(RNG_PERIOD)) u_chk (.clk_sys, .rstn, .reg_addr, .reg_wdata,
  .reg_wr, .reg_rd, .reg_rdata, .irq, .monitor_enable, .low_threshold_sel, .high_threshold_sel, .current_above_high,
  .current_below_low, .contactless_unit_rng_run, .rng_running, .secure_switch_enable, .secure_switch_overload,
  .secure_signal_in_pad, .auxiliary_port_pin_pad, .secure_signal_in, .auxiliary_port_pin);
